// ===== pkg/ovs_consts.vh
// Purpose: Constants for the overvoltage stage block/timing logic
// Assumes: 200 MHz core clock, 5 ms processing tick
// Notes:   Times are counted in 5 ms ticks unless named otherwise
`ifndef OVS_CONSTS_VH
`define OVS_CONSTS_VH

// Clock and time bases
`define OVS_CLK_MHZ        200
`define OVS_TICK_MS        5
`define OVS_STAMP_MS       1
`define OVS_TICK_CYC       (`OVS_TICK_MS * `OVS_CLK_MHZ * 1000)
`define OVS_STAMP_CYC      (`OVS_STAMP_MS * `OVS_CLK_MHZ * 1000)
`define OVS_BLK_LEAD_MS    5
// Longest published time, 1800 s in ticks
`define OVS_MAX_TICKS      20'h57E40
// Dropout at 97 % of setting
`define OVS_HYST_PCT       24'h000061
`define OVS_UNITY          16'h0064

// Register byte offsets
`define OVS_A_CTRL         8'h00
`define OVS_A_USET         8'h04
`define OVS_A_DT           8'h08
`define OVS_A_K            8'h0C
`define OVS_A_EXP          8'h10
`define OVS_A_REL          8'h14
`define OVS_A_STAT         8'h18
`define OVS_A_REMAIN       8'h1C
`define OVS_A_EXPECT       8'h20
`define OVS_A_RAT_AB       8'h24
`define OVS_A_RAT_CM       8'h28

// Control field positions (two-bit yes/no fields DREL, TRST, CONT: 1 = no, 2 = yes)
`define OVS_F_DTYPE        1:0
`define OVS_F_DREL         3:2
`define OVS_F_TRST         5:4
`define OVS_F_CONT         7:6
`define OVS_F_PMODE        9:8
`define OVS_B_FEN          10
`define OVS_B_FBLK         11
`define OVS_CODE_DT        2'h1
`define OVS_CODE_IDMT      2'h2
`define OVS_CODE_YES       2'h2

// Reset values
`define OVS_RST_CTRL       12'h069
`define OVS_RST_USET       16'h0069
`define OVS_RST_DT         16'h0008
`define OVS_RST_K          16'h0005
`define OVS_RST_EXP        16'h0064
`define OVS_RST_REL        16'h000C

`endif

// ===== rtl/ovs_stage.v
// Purpose: Blocking check and operate/release timing of one overvoltage
//          stage, with APB register access and event output
// Assumes: Voltages, block input from logic on core_clk; one clock
// Notes:   Voltages and setting share one unit; ratios in hundredths
// Functional notes
// - Blocking input sampled at each tick before pick-up is evaluated.
// - Pick-up without block asserts start and starts operate timing.
// - Pick-up with block asserts blocked; no start, no trip.
// - Block during start runs release timing; start drops at once unless delayed release is on.
// - Entering blocked emits stamped event with start voltage, fault type.
// - Instant operation trips in the same cycle as start.
// - Definite time trips after delay of continuous pick-up.
// - Inverse time: t = k / ((ratio)^a - 1).
// - Delay type code 1 definite, code 2 inverse.
// - Definite delay in 5 ms steps, default 40 ms; zero is instant.
// - Dial k in 0.01 s steps, default 0.05 s, inverse only.
// - Exponent a in 0.01 steps, default 1.00, on the ratio.
// - Release delay in 5 ms steps, default 60 ms, holds start.
// - Delayed release code 1 no, 2 yes; start clears after delay.
// - Timer reset after release on: clear after release time.
// - Continue option keeps operate counter running during release.
// - During release no trip unless pick-up returns.
// - Remaining time to trip published in 5 ms steps.
// - Per-phase and measured voltage ratios to setting, in 0.01.
// - Expected operate time published, recomputed in inverse mode.
// - Stage forcing lets a software switch drive the block input.
// - Pick-up drops out below 97 % of setting.
// - Pick-up needs one, two or three voltages: codes 0, 1, 2.
// - Start, trip, blocked changes give on/off events, 1 ms stamps.
`timescale 1ns/1ps
`include "ovs_consts.vh"

module ovs_stage #(
    parameter TICK_CYC  = `OVS_TICK_CYC,
    parameter STAMP_CYC = `OVS_STAMP_CYC
) (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [15:0] u_a,
    input  wire [15:0] u_b,
    input  wire [15:0] u_c,
    input  wire [15:0] measured_voltage,
    input  wire        block_in,
    output reg         start_o,
    output reg         trip_o,
    output reg         blocked_o,
    output reg         evt_stb,
    output reg  [5:0]  evt_code,
    output reg  [31:0] evt_time_ms,
    output reg  [15:0] evt_volt,
    output reg  [2:0]  evt_fault
);

    // One-hot states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RUN  = 4'h2;
    localparam [3:0] ST_REL  = 4'h4;
    localparam [3:0] ST_BLK  = 4'h8;

    // Ratio to setting in hundredths, saturating
    function [15:0] ratio;
        input [15:0] v;
        input [15:0] s;
        reg   [23:0] q;
        begin
            q = (s == 16'h0000) ? 24'hFFFFFF : ({8'h00, v} * 24'h64) / s;
            ratio = (q > 24'h00FFFF) ? 16'hFFFF : q[15:0];
        end
    endfunction

    // r^a in hundredths by piecewise-linear log2 and exp2
    function [15:0] pow_h;
        input [15:0] r;
        input [15:0] a;
        reg   [23:0] rq;
        reg   [23:0] nrm;
        reg   [4:0]  m;
        reg   [31:0] lg;
        reg   [31:0] pr;
        reg   [31:0] val;
        integer      i;
        begin
            rq = ({8'h00, r} << 8) / 24'h64;
            m = 5'h00;
            for (i = 0; i < 24; i = i + 1)
                if (rq[i])
                    m = i[4:0];
            nrm = rq << (5'h17 - m);
            lg = {27'h0, m} * 32'h100 + {24'h0, nrm[22:15]};
            pow_h = `OVS_UNITY;
            if (lg > 32'h800)
            begin
                pr = ((lg - 32'h800) * {16'h0, a}) / 32'h64;
                if (pr >= 32'h1000)
                    pow_h = 16'hFFFF;
                else
                begin
                    val = ((32'h100 + {24'h0, pr[7:0]}) * 32'h64)
                          << pr[11:8];
                    val = val >> 8;
                    pow_h = (val > 32'hFFFF) ? 16'hFFFF : val[15:0];
                end
            end
        end
    endfunction

    // Settings
    reg  [11:0] ctrl_q;
    reg  [15:0] uset_q;
    reg  [15:0] dt_q;
    reg  [15:0] k_q;
    reg  [15:0] exp_q;
    reg  [15:0] rel_q;
    // Stage state
    reg  [3:0]  st_q;
    reg  [3:0]  st_d;
    reg  [19:0] op_q;
    reg  [19:0] op_d;
    reg  [15:0] rc_q;
    reg  [15:0] rc_d;
    reg         start_d;
    reg         trip_d;
    reg         blk_d;
    reg  [2:0]  over_q;
    reg         blk_s_q;
    reg  [19:0] tgt_q;
    reg  [19:0] tgt_d;
    reg  [15:0] rat_a_q;
    reg  [15:0] rat_b_q;
    reg  [15:0] rat_c_q;
    reg  [15:0] rat_m_q;
    reg  [15:0] su_volt_q;
    reg  [2:0]  su_flt_q;
    reg  [31:0] tick_cnt_q;
    reg  [31:0] ms_cnt_q;
    reg  [31:0] ms_q;
    reg         tick_q;

    wire        is_idmt = (ctrl_q[`OVS_F_DTYPE] == `OVS_CODE_IDMT);
    wire        drel    = (ctrl_q[`OVS_F_DREL] == `OVS_CODE_YES);
    wire        trst    = (ctrl_q[`OVS_F_TRST] == `OVS_CODE_YES);
    wire        cont    = (ctrl_q[`OVS_F_CONT] == `OVS_CODE_YES);
    wire [1:0]  pmode   = ctrl_q[`OVS_F_PMODE];

    // Software switch overrides the matrix while forcing is on
    wire        blk_src = ctrl_q[`OVS_B_FEN] ? ctrl_q[`OVS_B_FBLK]
                                              : block_in;

    // Per-phase comparator with hysteresis held by the phase flag
    wire [23:0] thr_dn  = {8'h00, uset_q} * `OVS_HYST_PCT;
    wire [2:0]  over_d;
    assign over_d[0] = over_q[0] ? ({8'h00, u_a} * 24'h64 >= thr_dn)
                                 : (u_a > uset_q);
    assign over_d[1] = over_q[1] ? ({8'h00, u_b} * 24'h64 >= thr_dn)
                                 : (u_b > uset_q);
    assign over_d[2] = over_q[2] ? ({8'h00, u_c} * 24'h64 >= thr_dn)
                                 : (u_c > uset_q);
    wire [1:0]  n_over  = {1'b0, over_q[0]} + {1'b0, over_q[1]}
                        + {1'b0, over_q[2]};
    wire        pu      = (n_over > pmode);

    // Target in ticks; recomputed every tick in inverse mode
    wire [15:0] pw      = pow_h(rat_m_q, exp_q);
    wire [31:0] idmt_t  = (pw <= `OVS_UNITY) ? {12'h0, `OVS_MAX_TICKS}
                        : ({16'h0, k_q} * 32'hC8)
                          / {16'h0, pw - `OVS_UNITY};
    always @*
    begin
        if (is_idmt)
            tgt_d = (idmt_t > {12'h0, `OVS_MAX_TICKS}) ? `OVS_MAX_TICKS
                                                       : idmt_t[19:0];
        else
            tgt_d = {4'h0, dt_q};
    end

    // Tick and millisecond stamp generators
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
            ms_cnt_q   <= 32'h0;
            ms_q       <= 32'h0;
        end
        else
        begin
            tick_q     <= (tick_cnt_q == TICK_CYC - 1);
            tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? 32'h0
                                                       : tick_cnt_q + 32'h1;
            ms_cnt_q   <= (ms_cnt_q == STAMP_CYC - 1) ? 32'h0
                                                      : ms_cnt_q + 32'h1;
            if (ms_cnt_q == STAMP_CYC - 1)
                ms_q <= ms_q + 32'h1;
        end
    end

    // Stage sequencing, evaluated on the tick after block sampling
    always @*
    begin
        st_d    = st_q;
        op_d    = op_q;
        rc_d    = rc_q;
        start_d = start_o;
        trip_d  = trip_o;
        blk_d   = blocked_o;
        case (st_q)
            ST_IDLE:
            begin
                op_d = 20'h0;
                rc_d = 16'h0;
                if (pu && blk_s_q)
                begin
                    st_d  = ST_BLK;
                    blk_d = 1'b1;
                end
                else if (pu)
                begin
                    st_d    = ST_RUN;
                    start_d = 1'b1;
                    trip_d  = (tgt_q == 20'h0);
                end
            end
            ST_RUN:
            begin
                if (blk_s_q || !pu)
                begin
                    // Same release path for block and pick-up drop
                    st_d    = ST_REL;
                    rc_d    = 16'h0;
                    start_d = drel;
                    trip_d  = 1'b0;
                    if (!trst && !cont)
                        op_d = 20'h0;
                end
                else
                begin
                    op_d   = (op_q == 20'hFFFFF) ? op_q : op_q + 20'h1;
                    trip_d = (op_d >= tgt_q);
                end
            end
            ST_REL:
            begin
                rc_d = rc_q + 16'h1;
                if (cont)
                    op_d = (op_q == 20'hFFFFF) ? op_q : op_q + 20'h1;
                if (pu && !blk_s_q)
                begin
                    // Re-pick-up resumes; trip only now possible
                    st_d    = ST_RUN;
                    start_d = 1'b1;
                    trip_d  = (op_d >= tgt_q);
                end
                else if (rc_d >= rel_q)
                begin
                    st_d    = ST_IDLE;
                    start_d = 1'b0;
                    op_d    = 20'h0;
                end
            end
            ST_BLK:
            begin
                if (!pu || !blk_s_q)
                begin
                    st_d  = ST_IDLE;
                    blk_d = 1'b0;
                end
            end
            default:
            begin
                st_d    = ST_IDLE;
                start_d = 1'b0;
                trip_d  = 1'b0;
                blk_d   = 1'b0;
            end
        endcase
    end

    // Stage registers and event generation
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q        <= ST_IDLE;
            op_q        <= 20'h0;
            rc_q        <= 16'h0;
            start_o     <= 1'b0;
            trip_o      <= 1'b0;
            blocked_o   <= 1'b0;
            over_q      <= 3'h0;
            blk_s_q     <= 1'b0;
            tgt_q       <= 20'h0;
            rat_a_q     <= 16'h0;
            rat_b_q     <= 16'h0;
            rat_c_q     <= 16'h0;
            rat_m_q     <= 16'h0;
            su_volt_q   <= 16'h0;
            su_flt_q    <= 3'h0;
            evt_stb     <= 1'b0;
            evt_code    <= 6'h0;
            evt_time_ms <= 32'h0;
            evt_volt    <= 16'h0;
            evt_fault   <= 3'h0;
        end
        else
        begin
            evt_stb <= 1'b0;
            rat_a_q <= ratio(u_a, uset_q);
            rat_b_q <= ratio(u_b, uset_q);
            rat_c_q <= ratio(u_c, uset_q);
            rat_m_q <= ratio(measured_voltage, uset_q);
            if (tick_q)
            begin
                // Block and comparator sampled first; acted on next tick
                blk_s_q <= blk_src;
                over_q  <= over_d;
                tgt_q   <= tgt_d;
                if (st_q == ST_IDLE && pu)
                begin
                    su_volt_q <= measured_voltage;
                    su_flt_q  <= over_q;
                end
            end
            if (tick_q && (st_q != ST_IDLE || pu))
            begin
                st_q      <= st_d;
                op_q      <= op_d;
                rc_q      <= rc_d;
                start_o   <= start_d;
                trip_o    <= trip_d;
                blocked_o <= blk_d;
                if ({start_d, trip_d, blk_d}
                    != {start_o, trip_o, blocked_o})
                begin
                    // One strobe reports all edges of this tick
                    evt_stb     <= 1'b1;
                    evt_code    <= {start_d, trip_d, blk_d,
                                    start_d ^ start_o, trip_d ^ trip_o,
                                    blk_d ^ blocked_o};
                    evt_time_ms <= ms_q;
                    evt_volt    <= (st_q == ST_IDLE) ? measured_voltage
                                                     : su_volt_q;
                    evt_fault   <= (st_q == ST_IDLE) ? over_q : su_flt_q;
                end
            end
        end
    end

    // Remaining time, zero whenever the state is not ST_RUN
    wire [19:0] remain = (st_q == ST_RUN && tgt_q > op_q)
                       ? tgt_q - op_q : 20'h0;

    // APB slave: zero-wait access, unmapped offsets answer an error
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            ctrl_q  <= `OVS_RST_CTRL;
            uset_q  <= `OVS_RST_USET;
            dt_q    <= `OVS_RST_DT;
            k_q     <= `OVS_RST_K;
            exp_q   <= `OVS_RST_EXP;
            rel_q   <= `OVS_RST_REL;
        end
        else
        begin
            pready  <= psel && !penable && !pready;
            pslverr <= 1'b0;
            if (psel && !penable && !pready)
            begin
                prdata <= 32'h0;
                case (paddr)
                    `OVS_A_CTRL:   prdata <= {20'h0, ctrl_q};
                    `OVS_A_USET:   prdata <= {16'h0, uset_q};
                    `OVS_A_DT:     prdata <= {16'h0, dt_q};
                    `OVS_A_K:      prdata <= {16'h0, k_q};
                    `OVS_A_EXP:    prdata <= {16'h0, exp_q};
                    `OVS_A_REL:    prdata <= {16'h0, rel_q};
                    `OVS_A_STAT:   prdata <= {24'h0, st_q, pu,
                                              blocked_o, trip_o, start_o};
                    `OVS_A_REMAIN: prdata <= {12'h0, remain};
                    `OVS_A_EXPECT: prdata <= {12'h0, tgt_q};
                    `OVS_A_RAT_AB: prdata <= {rat_b_q, rat_a_q};
                    `OVS_A_RAT_CM: prdata <= {rat_m_q, rat_c_q};
                    default:       pslverr <= 1'b1;
                endcase
            end
            // Write lands at the completing edge
            if (psel && penable && pready && pwrite)
            begin
                case (paddr)
                    `OVS_A_CTRL: ctrl_q <= pwdata[11:0];
                    `OVS_A_USET: uset_q <= pwdata[15:0];
                    `OVS_A_DT:   dt_q   <= pwdata[15:0];
                    `OVS_A_K:    k_q    <= pwdata[15:0];
                    `OVS_A_EXP:  exp_q  <= pwdata[15:0];
                    `OVS_A_REL:  rel_q  <= pwdata[15:0];
                    default:     ctrl_q <= ctrl_q;
                endcase
            end
        end
    end

endmodule // ovs_stage

// ===== verif/ovs_stage_sva.sv
// Purpose: Port-level assertions for the overvoltage stage
// Assumes: Bound into every ovs_stage instance
// Notes:   Tick spacing checked through a gap counter
`timescale 1ns/1ps
module ovs_stage_chk #(
    parameter TICK_CYC = 20
) (
    input wire        core_clk,
    input wire        arst_n,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        start_o,
    input wire        trip_o,
    input wire        blocked_o,
    input wire        evt_stb,
    input wire [5:0]  evt_code
);
    wire [2:0]  outs = {start_o, trip_o, blocked_o};
    reg  [2:0]  outs_q;
    reg  [31:0] gap_q;
    reg         seen_q;
    wire        chg = (outs != outs_q);
    // Gap counter; first change only arms it
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outs_q <= 3'h0;
            gap_q  <= 32'h0;
            seen_q <= 1'b0;
        end
        else
        begin
            outs_q <= outs;
            gap_q  <= chg ? 32'h0 : gap_q + 32'h1;
            seen_q <= seen_q | chg;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_tick_spacing: assert property (chg && seen_q |->
        (gap_q % TICK_CYC) == TICK_CYC - 1) else $error("off-tick change");
    a_evt_iff_chg: assert property (chg == evt_stb)
        else $error("event strobe not tied to output change");
    a_evt_new_val: assert property (evt_stb |-> evt_code[5:3] == outs)
        else $error("event new values wrong");
    a_evt_chg_bits: assert property (evt_stb |->
        evt_code[2:0] == (outs ^ outs_q)) else $error("event change bits");
    a_blk_no_start: assert property (blocked_o |-> !start_o)
        else $error("start while blocked");
    a_trip_has_start: assert property (trip_o |-> start_o)
        else $error("trip without start");
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_apb_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_apb_unmapped: assert property (psel && !penable && !pwrite &&
        paddr > 8'h28 |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    c_instant: cover property (evt_stb && evt_code == 6'h36);
    c_blocked: cover property (evt_stb && evt_code == 6'h09);
    c_trip:    cover property (evt_stb && evt_code == 6'h32);
endmodule // ovs_stage_chk

bind ovs_stage ovs_stage_chk #(.TICK_CYC(TICK_CYC)) i_chk (
    .core_clk(core_clk), .arst_n(arst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
    .evt_stb(evt_stb), .evt_code(evt_code));

// ===== verif/ovs_src.sv
// Purpose: Voltage source and blocking matrix facing the stage
// Assumes: Bench sets requested levels just after a clock edge
// Notes:   Outputs registered, as the measurement path would be
`timescale 1ns/1ps
module ovs_src (
    input  wire        core_clk,
    input  wire        arst_n,
    input  wire [63:0] v_req,
    input  wire        blk_req,
    output reg  [15:0] u_a,
    output reg  [15:0] u_b,
    output reg  [15:0] u_c,
    output reg  [15:0] measured_voltage,
    output reg         block_in
);
    // Levels and block follow requests, one clock later
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            {measured_voltage, u_c, u_b, u_a} <= 64'h0;
            block_in <= 1'b0;
        end
        else
        begin
            {measured_voltage, u_c, u_b, u_a} <= v_req;
            block_in <= blk_req;
        end
    end
endmodule // ovs_src

// ===== verif/tb_overvoltage_stage_block_and_timing.sv
// Purpose: Self-checking bench for the overvoltage stage
// Assumes: Tick shortened to 20 cycles, stamp to 4
// Notes:   Driver notes expectations, monitor compares them
`timescale 1ns/1ps
module tb_overvoltage_stage_block_and_timing;
    localparam TK = 20;
    localparam [63:0] V1 = 64'h0080_0000_0000_0080;
    reg         core_clk = 1'b0;
    reg         arst_n = 1'b0;
    reg  [7:0]  paddr;
    reg         psel, penable, pwrite, blk_req, evt_on, st_l, tr_l;
    reg  [31:0] pwdata;
    reg  [63:0] v_req;
    wire [31:0] prdata, evt_time_ms;
    wire        pready, pslverr, block_in;
    wire        start_o, trip_o, blocked_o, evt_stb;
    wire [15:0] u_a, u_b, u_c, measured_voltage, evt_volt;
    wire [5:0]  evt_code;
    wire [2:0]  evt_fault;
    integer     fails, n_checks, cyc, t0, ts0, i;
    reg  [32:0] rq[$];
    reg  [25:0] eq[$];
    reg  [25:0] en;
    integer     dq[$];
    reg  [15:0] r[0:3];

    always #2.5 core_clk = ~core_clk;

    ovs_stage #(.TICK_CYC(TK), .STAMP_CYC(4)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .u_a(u_a), .u_b(u_b), .u_c(u_c),
        .measured_voltage(measured_voltage), .block_in(block_in),
        .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
        .evt_stb(evt_stb), .evt_code(evt_code),
        .evt_time_ms(evt_time_ms), .evt_volt(evt_volt),
        .evt_fault(evt_fault));
    ovs_src i_src (
        .core_clk(core_clk), .arst_n(arst_n), .v_req(v_req),
        .blk_req(blk_req), .u_a(u_a), .u_b(u_b), .u_c(u_c),
        .measured_voltage(measured_voltage), .block_in(block_in));

    task summarize;
    begin
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task cmp_v(input [79:0] nm, input [32:0] e, input [32:0] s);
    begin
        n_checks = n_checks + 1;
        if (s !== e)
        begin
            fails = fails + 1;
            $display("MISMATCH %0s exp %0h got %0h", nm, e, s);
        end
    end
    endtask
    task cmp_d(input integer e, input integer s);
    begin
        n_checks = n_checks + 1;
        if (s != e)
        begin
            fails = fails + 1;
            $display("MISMATCH op_delay exp %0d got %0d", e, s);
        end
    end
    endtask
    // APB master: setup, access, hold until pready
    task apb(input [7:0] a, input w, input [31:0] d);
    begin
        @(posedge core_clk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    end
    endtask
    task rd(input [7:0] a, input [32:0] e);
    begin
        rq.push_back(e);
        apb(a, 1'b0, $urandom);
    end
    endtask
    task ticks(input integer n);
        repeat (n * TK) @(posedge core_clk);
    endtask
    task fault(input [63:0] v);
    begin
        @(posedge core_clk);
        v_req <= v;
    end
    endtask
    task drain;
        integer k;
    begin
        for (k = 0; k < 3000 && eq.size() + dq.size() > 0; k = k + 1)
            @(posedge core_clk);
        cmp_v("pending", 33'h0, eq.size() + dq.size());
        eq.delete();
        dq.delete();
    end
    endtask
    // Quiet return to idle, events ignored meanwhile
    task settle;
    begin
        evt_on <= 1'b0;
        fault(64'h0);
        blk_req <= 1'b0;
        apb(8'h00, 1'b1, 32'h65);
        ticks(6);
        evt_on <= 1'b1;
    end
    endtask

    // Monitor takes the oldest note as each result shows
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
            cmp_v("read", rq.pop_front(), {pslverr, prdata});
        if (evt_stb === 1'b1 && evt_on)
        begin
            en = (eq.size() > 0) ? eq.pop_front() : 26'h0;
            if (en[25])
                cmp_v("evt_info", en[24:6], {evt_fault, evt_volt});
            cmp_v("evt_code", en[5:0], evt_code);
        end
        if (start_o === 1'b1 && !st_l)
        begin
            t0 = cyc;
            ts0 = evt_time_ms;
        end
        // Stamp runs at one count per 4 cycles here
        if (trip_o === 1'b1 && !tr_l && dq.size() > 0)
        begin
            cmp_v("stamp_ms", dq[0] / 4, evt_time_ms - ts0);
            cmp_d(dq.pop_front(), cyc - t0);
        end
        st_l = (start_o === 1'b1);
        tr_l = (trip_o === 1'b1);
    end

    // Hang guard, far beyond the planned run
    initial
    begin
        #200000;
        fails = fails + 1;
        $display("MISMATCH watchdog exp done got hang");
        summarize;
    end

    initial
    begin
        {fails, n_checks, cyc, t0} = 0;
        {psel, penable, pwrite, paddr, pwdata} = 0;
        {v_req, blk_req, st_l, tr_l} = 0;
        evt_on = 1'b1;
        i = $urandom(92436);
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values, unmapped place refused
        rd(8'h00, 33'h69);
        rd(8'h08, 33'h8);
        rd(8'h0C, 33'h5);
        rd(8'h10, 33'h64);
        rd(8'h14, 33'hC);
        apb(8'h30, 1'b1, 32'hFFFF);
        rd(8'h30, 33'h100000000);
        apb(8'h04, 1'b1, 32'h64);
        // Ratios at setting 100 equal the raw voltages
        for (i = 0; i < 4; i = i + 1)
            r[i] = $urandom % 100;
        fault({r[3], r[2], r[1], r[0]});
        ticks(3);
        rd(8'h24, {1'b0, r[1], r[0]});
        rd(8'h28, {1'b0, r[3], r[2]});
        // Definite time 2 ticks, delayed release 3 ticks
        apb(8'h08, 1'b1, 32'h2);
        apb(8'h14, 1'b1, 32'h3);
        eq.push_back(26'h24);
        eq.push_back(26'h32);
        dq.push_back(2 * TK);
        fault(V1);
        drain;
        eq.push_back(26'h22);
        eq.push_back(26'h04);
        fault(64'h0);
        drain;
        // Zero delay acts as instant, release immediate
        apb(8'h00, 1'b1, 32'h65);
        apb(8'h08, 1'b1, 32'h0);
        eq.push_back(26'h36);
        dq.push_back(0);
        fault(V1);
        drain;
        eq.push_back(26'h06);
        fault(64'h0);
        drain;
        // Release must run out before the next pick-up
        settle;
        // Inverse time: ratio 2, a 1.00, k 0.05 s gives 10 ticks
        apb(8'h00, 1'b1, 32'h66);
        eq.push_back(26'h24);
        eq.push_back(26'h32);
        dq.push_back(10 * TK);
        fault(64'h00C8_0000_0000_00C8);
        drain;
        rd(8'h20, 33'hA);
        settle;
        // Mode 2 wants all three phases over; one is not enough
        apb(8'h00, 1'b1, 32'h265);
        fault(V1);
        ticks(3);
        cmp_v("start", 33'h0, start_o);
        settle;
        // Block from the input, then from forcing
        for (i = 0; i < 2; i = i + 1)
        begin
            apb(8'h00, 1'b1, (i == 0) ? 32'h65 : 32'hC65);
            blk_req <= (i == 0);
            ticks(2);
            eq.push_back({1'b1, 3'h1, 16'h0080, 6'h09});
            fault(V1);
            drain;
            settle;
        end
        // Block arriving while the operate timer runs
        apb(8'h08, 1'b1, 32'h14);
        eq.push_back(26'h24);
        fault(V1);
        drain;
        // Just after start the full 20 ticks remain
        rd(8'h1C, 33'h14);
        ticks(4);
        blk_req <= 1'b1;
        evt_on <= 1'b0;
        ticks(3);
        cmp_v("start", 33'h0, start_o);
        ticks(20);
        cmp_v("trip", 33'h0, trip_o);
        settle;
        summarize;
    end
endmodule // tb_overvoltage_stage_block_and_timing
